// ==== field_memory_write_port_tb_top.sv ====
// Self-checking bench for the field memory write port
`timescale 1ns/1ps
module field_memory_write_port_tb_top;
  import fmw_pkg::*;
  localparam int LIMIT = 40000;
  logic aclk, aresetn;
  logic write_port_clock, write_pointer_reset, write_advance_enable, input_store_enable;
  logic [DATA_W-1:0] write_data_in;
  logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  int error_cnt, cmp_count, cyc, m_ptr;
  int seed = 67915;
  bit m_rst, m_padv, m_pst, m_pend, m_blk, m_hold;
  logic [DATA_W-1:0] m_mem [int];

  fmw_write_port #(.STAGE_DEPTH(BLOCK_WORDS)) i_dut (.aclk, .aresetn, .write_port_clock,
    .write_pointer_reset, .write_advance_enable, .input_store_enable, .write_data_in,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  fmw_ctl_model i_ctl (.aclk, .write_port_clock, .write_pointer_reset,
    .write_advance_enable, .input_store_enable, .write_data_in);

  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  function automatic logic [DATA_W-1:0] rnd();
    return DATA_W'($random(seed));
  endfunction : rnd

  // Ready is combinational and inputs only move after a rising edge, so the falling edge
  // shows exactly what the next rising edge will sample
  task automatic axi_wr(input logic [AXI_AW-1:0] a, input logic [31:0] d);
    bit ta, tw, done;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    done = 0;
    while (!done)
    begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      done = s_axi_bvalid;
      rr = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [AXI_AW-1:0] a);
    bit ta, done;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    done = 0;
    while (!done)
    begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      done = s_axi_rvalid;
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic rd_chk(input logic [AXI_AW-1:0] a, input logic [31:0] exp, input string what);
    axi_rd(a);
    check(what, rv, exp);
  endtask : rd_chk

  // One write edge on the pins and the same edge in the reference model
  task automatic ed(input bit rst, input bit adv, input bit st, input logic [DATA_W-1:0] d);
    i_ctl.pulse(rst, adv, st, d, $unsigned($random(seed)) % 3);
    if (rst && !m_rst)
    begin
      m_pend = 1;
      m_blk = 0;
    end
    if (m_padv && m_pst && !m_blk)
      m_mem[m_ptr] = d;
    if (adv && !m_blk)
    begin
      if (m_pend)
        m_ptr = 0;
      else if (!m_hold)
        m_ptr = (m_ptr == 245771) ? 12 : m_ptr + 1;
      m_pend = 0;
      m_hold = 0;
    end
    m_rst = rst;
    m_padv = adv;
    m_pst = st;
  endtask : ed

  // Random store mask and advance gaps until n active edges have passed
  task automatic run(input int n);
    int act;
    bit a;
    act = 0;
    while (act < n)
    begin
      a = ($random(seed) & 7) != 0;
      ed(1'b0, a, 1'($random(seed)), rnd());
      act += a;
    end
    rd_chk(REG_WPTR, m_ptr, "write pointer");
  endtask : run

  task automatic plain_rst();
    ed(0, 1, 0, rnd());
    ed(1, 0, 0, rnd());
    rd_chk(REG_WPTR, m_ptr, "pointer before clear");
    ed(1, 1, 1, rnd());
    rd_chk(REG_WPTR, 0, "pointer after clear");
  endtask : plain_rst

  task automatic blk_seq(input bit ie, input int blk);
    logic [12:0] b;
    b = 13'(blk);
    ed(0, 1, 0, rnd());
    ed(1, 1, 0, rnd());
    ed(0, 1, 0, rnd());
    ed(0, 0, 1, rnd());
    ed(0, 0, 1, rnd());
    rd_chk(REG_WPTR, m_ptr, "qualifier edges");
    m_blk = 1;
    for (int i = 12; i >= 0; i--)
      if (ie) ed(0, i == 12, b[i], rnd());
      else ed(0, 0, 0, (rnd() & 12'hFFE) | b[i]);
    if (blk > 6143)
    begin
      axi_rd(REG_STATUS);
      check("lock flag", rv[3], 1);
      return;
    end
    m_ptr = 12 + 40 * blk;
    rd_chk(REG_WPTR, m_ptr, "block start");
    rd_chk(REG_BLOCK, blk, "block address");
    repeat (18) ed(0, 0, 0, rnd());
    m_blk = 0;
    m_hold = 1;
    ed(0, 1, 1, rnd());
    rd_chk(REG_WPTR, m_ptr, "start held");
  endtask : blk_seq

  initial
  begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd_chk(REG_CTRL, 1, "ctrl reset");
    rd_chk(REG_WPTR, 0, "wptr reset");
    axi_wr(REG_WPTR, 32'h0000_0055);
    check("read-only write resp", rr, RESP_OKAY);
    rd_chk(REG_WPTR, 0, "wptr after write");
    axi_rd(8'h1C);
    check("unmapped resp", rr, RESP_SLVERR);
    $display("test registers done");
    plain_rst();
    run(60);
    $display("test plain fifo done");
    axi_wr(REG_CTRL, 0);
    repeat (3) i_ctl.pulse(0, 1, 1, rnd(), 0);
    rd_chk(REG_WPTR, m_ptr, "pointer while off");
    axi_wr(REG_CTRL, 1);
    plain_rst();
    run(56);
    $display("test port off done");
    blk_seq(0, $unsigned($random(seed)) % 6143);
    run(60);
    blk_seq(1, 6143);
    run(60);
    $display("test block access and wrap done");
    blk_seq(0, 6144);
    repeat (56) ed(0, 1, 0, rnd());
    plain_rst();
    run(56);
    plain_rst();
    $display("test lockup recovery done");
    // The final clear flushes the staging banks; give the drain time to finish
    repeat (100) @(posedge aclk);
    axi_rd(REG_STATUS);
    check("status after flush", rv[15:0], 16'h0000);
    foreach (m_mem[k])
    begin
      axi_wr(REG_RD_ADDR, k);
      rd_chk(REG_RD_DATA, m_mem[k], "core word");
    end
    $display("test readback done");
    report_and_stop();
  end
endmodule : field_memory_write_port_tb_top

// ==== fmw_ctl_model.sv ====
// Behavioural video controller that drives the write pins of the field memory
`timescale 1ns/1ps
module fmw_ctl_model
  import fmw_pkg::*;
(
  input wire logic aclk,
  output logic write_port_clock,
  output logic write_pointer_reset,
  output logic write_advance_enable,
  output logic input_store_enable,
  output logic [DATA_W-1:0] write_data_in
);
  initial
  begin
    write_port_clock = 1'b0;
    write_pointer_reset = 1'b0;
    write_advance_enable = 1'b0;
    input_store_enable = 1'b0;
    write_data_in = 12'h000;
  end
  // One write clock cycle; slow stretches both phases, the clock rests low between calls
  task automatic pulse(input logic rst, input logic adv, input logic st,
    input logic [DATA_W-1:0] d, input int slow);
    @(posedge aclk);
    write_pointer_reset <= rst;
    write_advance_enable <= adv;
    input_store_enable <= st;
    write_data_in <= d;
    repeat (2) @(posedge aclk);
    write_port_clock <= 1'b1;
    repeat (4 + slow) @(posedge aclk);
    write_port_clock <= 1'b0;
    // Past the hold time the word is stale; invert it so nothing can lean on it
    write_data_in <= ~d;
    repeat (1 + slow) @(posedge aclk);
  endtask : pulse
endmodule : fmw_ctl_model

// ==== fmw_pkg.sv ====
// Shared constants and types for the field memory write port
package fmw_pkg;
  localparam int DATA_W = 12;
  localparam int PTR_W = 18;
  localparam int BLK_W = 13;
  localparam int CORE_WORDS = 245760;
  localparam int BLOCK_WORDS = 40;
  localparam logic [PTR_W-1:0] PTR_RESET = 18'h00000;
  localparam logic [PTR_W-1:0] PTR_WRAP = 18'h0000C;
  localparam logic [PTR_W-1:0] PTR_MAX = 18'h3C00B;
  localparam logic [BLK_W-1:0] BLOCK_LAST = 13'h17FF;
  // Write-clock edge numbers counted from the reset edge (edge 1)
  localparam logic [5:0] EDGE_QUAL_PAIR = 6'h02;
  localparam logic [5:0] EDGE_QUAL_LAST = 6'h04;
  localparam logic [5:0] EDGE_LOAD_FIRST = 6'h05;
  localparam logic [5:0] EDGE_LOAD_LAST = 6'h11;
  localparam logic [5:0] EDGE_SETTLE_LAST = 6'h23;
  // Register bus
  localparam int AXI_AW = 8;
  localparam logic [AXI_AW-1:0] REG_CTRL = 8'h00;
  localparam logic [AXI_AW-1:0] REG_WPTR = 8'h04;
  localparam logic [AXI_AW-1:0] REG_STATUS = 8'h08;
  localparam logic [AXI_AW-1:0] REG_BLOCK = 8'h0C;
  localparam logic [AXI_AW-1:0] REG_RD_ADDR = 8'h10;
  localparam logic [AXI_AW-1:0] REG_RD_DATA = 8'h14;
  localparam logic CTRL_PORT_ON_RESET = 1'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {st_fifo, st_qual, st_load, st_settle, st_locked} fmw_state_type;
endpackage : fmw_pkg

// ==== fmw_stage_bank.sv ====
// Ping-pong staging of written words before they move into the core
`timescale 1ns/1ps
module fmw_stage_bank
  import fmw_pkg::*;
#(
  parameter int DEPTH = BLOCK_WORDS
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic word_valid,
  input wire logic [PTR_W-1:0] word_addr,
  input wire logic [DATA_W-1:0] word_data,
  input wire logic flush,
  output logic core_we,
  output logic [PTR_W-1:0] core_addr,
  output logic [DATA_W-1:0] core_data,
  output logic [7:0] staged_count,
  output logic overrun
);
  localparam int CW = $clog2(DEPTH + 1);

  generate
    if (DEPTH < 2 || CW > 8)
    begin : g_bad_depth
      $error("fmw_stage_bank: DEPTH must be 2 to 255");
    end
  endgenerate

  logic [DATA_W-1:0] data_mem [0:1][0:DEPTH-1];
  logic [PTR_W-1:0] addr_mem [0:1][0:DEPTH-1];
  logic [CW-1:0] count_q [0:1];
  logic [1:0] full_q;
  logic fill_q;
  logic drain_q;
  logic [CW-1:0] drain_idx_q;
  logic accept;
  logic commit;
  logic drain_done;

  // A bank still draining cannot take words; the write rate keeps this rare
  assign accept = word_valid && !full_q[fill_q];
  assign commit = !full_q[fill_q] && ((word_valid && count_q[fill_q] == CW'(DEPTH - 1))
                  || (flush && (word_valid || count_q[fill_q] != '0)));
  assign drain_done = full_q[drain_q] && drain_idx_q == count_q[drain_q] - CW'(1);
  assign staged_count = 8'(count_q[fill_q]);

  always_ff @(posedge aclk)
  begin
    if (accept)
    begin
      data_mem[fill_q][count_q[fill_q]] <= word_data;
      addr_mem[fill_q][count_q[fill_q]] <= word_addr;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_q[0] <= '0;
      count_q[1] <= '0;
      fill_q <= 1'b0;
      full_q <= 2'b00;
      overrun <= 1'b0;
    end
    else
    begin
      if (accept)
        count_q[fill_q] <= count_q[fill_q] + CW'(1);
      if (drain_done)
        count_q[drain_q] <= '0;
      if (commit)
      begin
        full_q[fill_q] <= 1'b1;
        fill_q <= !fill_q;
      end
      if (drain_done)
        full_q[drain_q] <= 1'b0;
      if (word_valid && full_q[fill_q])
        overrun <= 1'b1;
    end
  end

  // Words become readable only once their bank is copied into the core
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      drain_q <= 1'b0;
      drain_idx_q <= '0;
      core_we <= 1'b0;
      core_addr <= '0;
      core_data <= '0;
    end
    else
    begin
      core_we <= full_q[drain_q];
      core_addr <= addr_mem[drain_q][drain_idx_q];
      core_data <= data_mem[drain_q][drain_idx_q];
      if (drain_done)
      begin
        drain_idx_q <= '0;
        drain_q <= !drain_q;
      end
      else if (full_q[drain_q])
        drain_idx_q <= drain_idx_q + CW'(1);
    end
  end
endmodule : fmw_stage_bank

// ==== fmw_write_port.sv ====
// Write port of the field memory: pin sampling, pointer, block access and register slave
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module fmw_write_port
  import fmw_pkg::*;
#(
  parameter int STAGE_DEPTH = BLOCK_WORDS
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic write_port_clock,
  input wire logic write_pointer_reset,
  input wire logic write_advance_enable,
  input wire logic input_store_enable,
  input wire logic [DATA_W-1:0] write_data_in,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int PIN_W = DATA_W + 4;

  generate
    if (STAGE_DEPTH != BLOCK_WORDS || int'(PTR_MAX) != CORE_WORDS + int'(PTR_WRAP) - 1)
    begin : g_bad_geometry
      $error("fmw_write_port: staging depth or pointer range does not match the core");
    end
  endgenerate

  function automatic logic [PTR_W-1:0] block_start(input logic [BLK_W-1:0] blk);
    logic [PTR_W+1:0] s;
    s = (PTR_W+2)'(PTR_WRAP) + (PTR_W+2)'(blk) * (PTR_W+2)'(BLOCK_WORDS);
    return s[PTR_W-1:0];
  endfunction : block_start

  function automatic logic reg_known(input logic [AXI_AW-1:0] a);
    return a == REG_CTRL || a == REG_WPTR || a == REG_STATUS || a == REG_BLOCK
      || a == REG_RD_ADDR || a == REG_RD_DATA;
  endfunction : reg_known

  // Pins come from the controller's clock; two flops before any use
  logic [PIN_W-1:0] pin_meta_q;
  logic [PIN_W-1:0] pin_sync_q;
  logic clk_prev_q;
  logic wclk_s;
  logic rst_s;
  logic we_s;
  logic ie_s;
  logic [DATA_W-1:0] d_s;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
      clk_prev_q <= 1'b0;
    end
    else
    begin
      pin_meta_q <= {write_port_clock, write_pointer_reset, write_advance_enable,
                     input_store_enable, write_data_in};
      pin_sync_q <= pin_meta_q;
      clk_prev_q <= wclk_s;
    end
  end

  // Data and controls share the clock's sync delay, so setup at the pins carries over
  assign {wclk_s, rst_s, we_s, ie_s, d_s} = pin_sync_q;

  logic ctrl_port_on_q;
  logic wedge;
  logic rst_prev_q;
  logic rst_rise;
  fmw_state_type state_q;
  logic [5:0] edge_cnt_q;
  logic [5:0] edge_no;
  logic src_ie_q;
  logic [BLK_W-1:0] blk_q;
  logic [BLK_W-1:0] blk_next;
  logic load_bit;
  logic qual_ok;
  logic suppress;
  logic pend_q;
  logic [PTR_W-1:0] target_q;
  logic clear_now;
  logic load_now;
  logic [PTR_W-1:0] ptr_q;
  logic arm_q;
  logic first_word_q;
  logic word_valid;

  // Pointers are plain flops: nothing decays while the write clock pauses
  assign wedge = wclk_s && !clk_prev_q && ctrl_port_on_q;
  assign rst_rise = wedge && rst_s && !rst_prev_q;
  assign edge_no = rst_rise ? 6'h01 : edge_cnt_q + 6'h01;
  assign qual_ok = (edge_no <= EDGE_QUAL_PAIR) ? (!ie_s && we_s) : (ie_s && !we_s);
  assign load_bit = (edge_no == EDGE_LOAD_FIRST ? we_s : src_ie_q) ? ie_s : d_s[0];
  assign blk_next = {blk_q[BLK_W-2:0], load_bit};
  assign suppress = !rst_rise && (state_q == st_load || state_q == st_settle
                    || state_q == st_locked);
  assign load_now = wedge && !rst_rise && state_q == st_load && edge_no == EDGE_LOAD_LAST
                    && blk_next <= BLOCK_LAST;
  assign clear_now = wedge && we_s && !suppress && (pend_q || rst_rise);
  assign word_valid = wedge && arm_q && !suppress;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rst_prev_q <= 1'b0;
    else if (wedge)
      rst_prev_q <= rst_s;
  end

  // Qualifier and serial block address; the first four edges still act as plain FIFO
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= st_fifo;
      edge_cnt_q <= '0;
      src_ie_q <= 1'b0;
      blk_q <= '0;
    end
    else if (wedge)
    begin
      unique case (rst_rise ? st_qual : state_q)
        st_fifo, st_locked:
        begin
        end
        st_qual:
        begin
          edge_cnt_q <= edge_no;
          if (!qual_ok)
            state_q <= st_fifo;
          else if (edge_no == EDGE_QUAL_LAST)
            state_q <= st_load;
          else
            state_q <= st_qual;
        end
        st_load:
        begin
          edge_cnt_q <= edge_no;
          if (edge_no == EDGE_LOAD_FIRST)
            src_ie_q <= we_s;
          blk_q <= blk_next;
          if (edge_no == EDGE_LOAD_LAST)
            state_q <= (blk_next > BLOCK_LAST) ? st_locked : st_settle;
        end
        st_settle:
        begin
          edge_cnt_q <= edge_no;
          if (edge_no == EDGE_SETTLE_LAST)
            state_q <= st_fifo;
        end
      endcase
    end
  end

  // A pending clear remembers where the pointer lands on the next active edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pend_q <= 1'b0;
      target_q <= PTR_RESET;
    end
    else if (load_now)
    begin
      pend_q <= 1'b1;
      target_q <= block_start(blk_next);
    end
    else if (rst_rise)
    begin
      pend_q <= !we_s;
      target_q <= PTR_RESET;
    end
    else if (clear_now)
      pend_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ptr_q <= PTR_RESET;
    else if (load_now)
      ptr_q <= block_start(blk_next);
    else if (clear_now)
      ptr_q <= rst_rise ? PTR_RESET : target_q;
    else if (wedge && we_s && !suppress)
      ptr_q <= (ptr_q == PTR_MAX) ? PTR_WRAP : ptr_q + 18'h00001;
  end

  // Data at an edge is stored if both enables were high at the edge before
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arm_q <= 1'b0;
      first_word_q <= 1'b0;
    end
    else if (wedge)
    begin
      arm_q <= we_s && ie_s && !suppress;
      first_word_q <= clear_now && (rst_rise || target_q == PTR_RESET);
    end
  end

  logic core_we;
  logic [PTR_W-1:0] core_addr;
  logic [DATA_W-1:0] core_data;
  logic [7:0] staged_count;
  logic stage_overrun;

  fmw_stage_bank #(
    .DEPTH(STAGE_DEPTH)
  ) u_stage (
    .aclk(aclk),
    .aresetn(aresetn),
    .word_valid(word_valid),
    .word_addr(ptr_q),
    .word_data(d_s),
    .flush(clear_now || load_now),
    .core_we(core_we),
    .core_addr(core_addr),
    .core_data(core_data),
    .staged_count(staged_count),
    .overrun(stage_overrun)
  );

  // Core storage; the register read path never stalls the write side
  logic [DATA_W-1:0] core_mem [0:int'(PTR_MAX)];

  always_ff @(posedge aclk)
  begin
    if (core_we)
      core_mem[core_addr] <= core_data;
  end

  // Register slave
  logic aw_have_q;
  logic w_have_q;
  logic [AXI_AW-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write;
  logic [PTR_W-1:0] rd_addr_q;
  logic [PTR_W-1:0] rd_addr_d;
  logic [31:0] status_word;

  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
  assign status_word = {16'h0000, staged_count, 3'h0, stage_overrun,
                        state_q == st_locked, state_q == st_load || state_q == st_settle,
                        state_q == st_qual, pend_q};

  always_comb
  begin
    rd_addr_d = rd_addr_q;
    for (int b = 0; b < 2; b++)
    begin
      if (wstrb_q[b])
        rd_addr_d[8*b +: 8] = wdata_q[8*b +: 8];
    end
    // The third byte carries only the top pointer bits
    if (wstrb_q[2])
      rd_addr_d[PTR_W-1:16] = wdata_q[PTR_W-1:16];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      ctrl_port_on_q <= CTRL_PORT_ON_RESET;
      rd_addr_q <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= reg_known(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
        if (awaddr_q == REG_CTRL && wstrb_q[0])
          ctrl_port_on_q <= wdata_q[0];
        if (awaddr_q == REG_RD_ADDR)
          rd_addr_q <= rd_addr_d;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= reg_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        REG_CTRL: s_axi_rdata <= {31'h00000000, ctrl_port_on_q};
        REG_WPTR: s_axi_rdata <= {14'h0000, ptr_q};
        REG_STATUS: s_axi_rdata <= status_word;
        REG_BLOCK: s_axi_rdata <= {19'h00000, blk_q};
        REG_RD_ADDR: s_axi_rdata <= {14'h0000, rd_addr_q};
        REG_RD_DATA: s_axi_rdata <= (rd_addr_q <= PTR_MAX) ? {20'h00000, core_mem[rd_addr_q]}
                                    : 32'h00000000;
        default: s_axi_rdata <= 32'h00000000;
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_ptr_in_range: assert property (ptr_q <= PTR_MAX)
    else $error("write pointer beyond maximum");
  a_wrap_to_twelve: assert property (wedge && we_s && !suppress && !clear_now && !load_now
    && ptr_q == PTR_MAX |=> ptr_q == PTR_WRAP)
    else $error("pointer did not wrap to twelve");
  a_hold_no_adv: assert property (wedge && !we_s && !load_now |=> $stable(ptr_q))
    else $error("pointer moved without advance enable");
  a_reset_clears: assert property (rst_rise && we_s |=> ptr_q == PTR_RESET && !pend_q)
    else $error("pointer not cleared on reset edge");
  a_block_start: assert property (load_now |=> ptr_q == $past(block_start(blk_next)))
    else $error("block start value wrong");
  a_qual_fail: assert property (state_q == st_qual && wedge && !rst_rise && !qual_ok
    |=> state_q == st_fifo)
    else $error("failed qualifier did not return to plain mode");
  a_lock_freeze: assert property (state_q == st_locked && !rst_rise
    |=> $stable(ptr_q) && !word_valid)
    else $error("locked state moved the pointer");
  a_store_addr: assert property (word_valid && first_word_q |-> ptr_q == PTR_RESET)
    else $error("first word after clear not stored at address zero");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed while waiting");

  c_block_load: cover property (load_now);
  c_wrap: cover property (wedge && we_s && ptr_q == PTR_MAX);
  c_locked: cover property (state_q == st_locked);
  c_flush: cover property (clear_now && staged_count != 8'h00);
endmodule : fmw_write_port
